// ==== cache_pkg.sv ====
// Purpose: shared constants for the read pre-fetch / completion cache control
// Assumes: 16-bit configuration registers at even byte offsets
// Notes: every offset, field position and reset value is named here
package cache_pkg;

	// ************************************************************
	// register offsets (byte addresses in configuration space)
	// ************************************************************
	localparam logic [7:0] OFS_PREFETCH_LIMITS = 8'hE8;
	localparam logic [7:0] OFS_IDLE_START = 8'hEA;
	localparam logic [7:0] OFS_IDLE_FLOOR = 8'hEC;
	localparam logic [7:0] OFS_IDLE_CEILING = 8'hEE;

	// ************************************************************
	// field layout
	// ************************************************************
	localparam int LEN_LSB = 0;
	localparam int LEN_W = 4;
	localparam int POLICY_LSB = 6;
	localparam int POLICY_W = 2;
	localparam int BURST_LSB = 8;
	localparam int BURST_W = 4;
	localparam int START_W = 8;
	localparam int CLOCK_W = 12;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [1:0] RST_POLICY = 2'h0;
	localparam logic [3:0] RST_LEN = 4'h0;
	localparam logic [3:0] RST_BURST = 4'h0;
	localparam logic [7:0] RST_IDLE_START = 8'h08;
	localparam logic [11:0] RST_IDLE_FLOOR = 12'h07F;
	localparam logic [11:0] RST_IDLE_CEILING = 12'h1C0;

	// ************************************************************
	// cache policy codes and length encodings
	// ************************************************************
	localparam logic [1:0] POLICY_NONE = 2'h0;
	localparam logic [1:0] POLICY_LIGHT = 2'h1;
	localparam logic [1:0] POLICY_FULL = 2'h2;
	localparam logic [13:0] LEN_BASE_BYTES = 14'h0040;
	localparam logic [13:0] LEN_MAX_BYTES = 14'h2000;
	localparam logic [3:0] BURST_OFF = 4'h0;
	localparam logic [3:0] BURST_ONE = 4'h1;

	typedef enum logic [1:0] {
		ST_EMPTY = 2'b01,
		ST_CACHED = 2'b10
	} cache_state_t;

endpackage

// ==== idle_count_if.sv ====
// Purpose: carrier between the cache control and one idle counter
// Assumes: single clock domain
// Notes: reached is combinational from the counter's own register
`timescale 1ns/1ps
interface idle_count_if #(parameter int W = 8);
	logic clear;
	logic step;
	logic [W-1:0] limit;
	logic [W-1:0] count;
	logic reached;

	modport counter (input clear, input step, input limit,
		output count, output reached);
	modport user (output clear, output step, output limit,
		input count, input reached);
endinterface

// ==== idle_counter.sv ====
// Purpose: saturating idle counter with a limit compare
// Assumes: clear has priority over step
// Notes: saturation keeps a long idle stretch from wrapping back under limit
`timescale 1ns/1ps
module idle_counter #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// counter carrier
	idle_count_if.counter cnt
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic at_top;

	assign at_top = &count_r;
	assign count_nxt = cnt.clear ? '0 :
		(cnt.step && !at_top) ? count_r + 1'b1 : count_r;
	assign cnt.count = count_r;
	assign cnt.reached = (count_r >= cnt.limit);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule

// ==== cache_ctrl.sv ====
// How it works
// [R1] policy 00: no pre-fetch; discard leftover data once any data returned.
// [R2] policy 01: pre-fetch; discard on master end, keep on bridge retry; master end only discards once the transfer has returned data.
// [R3] policy 10: pre-fetch; keep leftover data on any transfer end.
// [R4] bits 5:4 of pre-fetch limits register always read zero.
// [R5] length code 0..7 gives 64 bytes doubling to 8 Kbytes; 8..F reserved.
// [R6] count cycle starts without hit; discard allowed at 8-bit limit, reset 8.
// [R7] miss-limit check waits for 12-bit idle clock floor, reset 007Fh.
// [R8] discard after 12-bit idle clock ceiling, reset 01C0h.
// [R9] unused upper bits of the idle limit registers read zero.
// [R10] fields reset on link reset, global reset pin or power-on reset.
// [R11] burst count 0 disables, 1 gives no extra reads, n gives n-1.
// [R12] any read hit restarts both idle counters from zero.
// [R13] undefined policy 11 behaves like policy 00.
//
// Purpose: control of the downstream read pre-fetch agent and completion
//          cache discard decisions, with its configuration registers
// Assumes: bridge datapath signals are on ref_clk; reset pins are async
// Notes: buffer storage and transaction-layer logic live elsewhere
`timescale 1ns/1ps
module cache_ctrl (
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// reset pins from outside the clock domain
	input wire logic link_side_reset_n,
	input wire logic global_pin_reset_n,
	// configuration access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	output logic cfg_rd_valid,
	// bridge datapath events
	input wire logic cpl_arrive,
	input wire logic read_hit,
	input wire logic pci_cycle_start,
	input wire logic data_returned,
	input wire logic end_by_master,
	input wire logic end_by_retry,
	// pre-fetch agent control
	output logic prefetch_enable,
	output logic [13:0] prefetch_read_bytes,
	output logic [3:0] prefetch_extra_reads,
	// cache status
	output logic cache_held,
	output logic cache_discard
);

	// ************************************************************
	// reset pin synchronisers
	// ************************************************************
	logic [2:0] link_sync_r;
	logic [2:0] glob_sync_r;
	logic link_lvl_r;
	logic glob_lvl_r;
	logic cfg_reset;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			link_sync_r <= 3'h7;
			glob_sync_r <= 3'h7;
		end else begin
			link_sync_r <= {link_sync_r[1:0], link_side_reset_n};
			glob_sync_r <= {glob_sync_r[1:0], global_pin_reset_n};
		end
	end

	// a level only counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			link_lvl_r <= 1'b1;
			glob_lvl_r <= 1'b1;
		end else begin
			if (link_sync_r[1] == link_sync_r[2]) begin
				link_lvl_r <= link_sync_r[2];
			end
			if (glob_sync_r[1] == glob_sync_r[2]) begin
				glob_lvl_r <= glob_sync_r[2];
			end
		end
	end

	assign cfg_reset = !reset_n || !link_lvl_r || !glob_lvl_r; // R10

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [1:0] policy_r;
	logic [3:0] len_code_r;
	logic [3:0] burst_r;
	logic [7:0] idle_start_r;
	logic [11:0] idle_floor_r;
	logic [11:0] idle_ceiling_r;
	logic sel_limits;
	logic sel_start;
	logic sel_floor;
	logic sel_ceiling;
	logic wr_lo;
	logic wr_hi;

	assign sel_limits = (cfg_addr == cache_pkg::OFS_PREFETCH_LIMITS);
	assign sel_start = (cfg_addr == cache_pkg::OFS_IDLE_START);
	assign sel_floor = (cfg_addr == cache_pkg::OFS_IDLE_FLOOR);
	assign sel_ceiling = (cfg_addr == cache_pkg::OFS_IDLE_CEILING);
	assign wr_lo = cfg_wr && cfg_be[0];
	assign wr_hi = cfg_wr && cfg_be[1];

	always_ff @(posedge ref_clk) begin
		if (cfg_reset) begin
			policy_r <= cache_pkg::RST_POLICY; // R10
			len_code_r <= cache_pkg::RST_LEN;
			burst_r <= cache_pkg::RST_BURST;
			idle_start_r <= cache_pkg::RST_IDLE_START; // R6
			idle_floor_r <= cache_pkg::RST_IDLE_FLOOR; // R7
			idle_ceiling_r <= cache_pkg::RST_IDLE_CEILING; // R8
		end else begin
			if (sel_limits && wr_lo) begin
				policy_r <= cfg_wdata[cache_pkg::POLICY_LSB +:
					cache_pkg::POLICY_W];
				len_code_r <= cfg_wdata[cache_pkg::LEN_LSB +:
					cache_pkg::LEN_W];
			end
			if (sel_limits && wr_hi) begin
				burst_r <= cfg_wdata[cache_pkg::BURST_LSB +:
					cache_pkg::BURST_W];
			end
			if (sel_start && wr_lo) begin
				idle_start_r <= cfg_wdata[cache_pkg::START_W-1:0];
			end
			if (sel_floor && wr_lo) begin
				idle_floor_r[7:0] <= cfg_wdata[7:0];
			end
			if (sel_floor && wr_hi) begin
				idle_floor_r[11:8] <= cfg_wdata[11:8];
			end
			if (sel_ceiling && wr_lo) begin
				idle_ceiling_r[7:0] <= cfg_wdata[7:0];
			end
			if (sel_ceiling && wr_hi) begin
				idle_ceiling_r[11:8] <= cfg_wdata[11:8];
			end
		end
	end

	// ************************************************************
	// read-back; reserved bits and unmapped offsets return zero
	// ************************************************************
	logic [15:0] rd_limits;
	logic [15:0] rd_start;
	logic [15:0] rd_floor;
	logic [15:0] rd_ceiling;
	logic [15:0] rd_mux;

	assign rd_limits = {4'h0, burst_r, policy_r, 2'h0, len_code_r}; // R4
	assign rd_start = {8'h00, idle_start_r}; // R9
	assign rd_floor = {4'h0, idle_floor_r}; // R9
	assign rd_ceiling = {4'h0, idle_ceiling_r}; // R9
	assign rd_mux = sel_limits ? rd_limits :
		sel_start ? rd_start :
		sel_floor ? rd_floor :
		sel_ceiling ? rd_ceiling : 16'h0000;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg_rdata <= 16'h0000;
			cfg_rd_valid <= 1'b0;
		end else begin
			cfg_rdata <= cfg_rd ? rd_mux : 16'h0000;
			cfg_rd_valid <= cfg_rd;
		end
	end

	// ************************************************************
	// pre-fetch agent settings
	// ************************************************************
	logic caching_on;
	logic pf_enable_nxt;
	logic [13:0] pf_bytes_nxt;
	logic [3:0] pf_extra_nxt;

	// policy 11 falls into the no-caching group
	assign caching_on = (policy_r == cache_pkg::POLICY_LIGHT) ||
		(policy_r == cache_pkg::POLICY_FULL); // R13
	assign pf_enable_nxt = caching_on &&
		(burst_r != cache_pkg::BURST_OFF); // R1 R2 R3 R11
	// reserved length codes clamp to the largest defined size
	assign pf_bytes_nxt = len_code_r[3] ? cache_pkg::LEN_MAX_BYTES :
		cache_pkg::LEN_BASE_BYTES << len_code_r[2:0]; // R5
	assign pf_extra_nxt = (burst_r > cache_pkg::BURST_ONE) ?
		burst_r - cache_pkg::BURST_ONE : 4'h0; // R11

	always_ff @(posedge ref_clk) begin
		if (cfg_reset) begin
			prefetch_enable <= 1'b0;
			prefetch_read_bytes <= cache_pkg::LEN_BASE_BYTES;
			prefetch_extra_reads <= 4'h0;
		end else begin
			prefetch_enable <= pf_enable_nxt;
			prefetch_read_bytes <= pf_bytes_nxt;
			prefetch_extra_reads <= pf_extra_nxt;
		end
	end

	// ************************************************************
	// idle counters
	// ************************************************************
	cache_pkg::cache_state_t state_r;
	cache_pkg::cache_state_t state_nxt;
	logic counters_clear;

	idle_count_if #(.W(cache_pkg::START_W)) start_cnt ();
	idle_count_if #(.W(cache_pkg::CLOCK_W)) clock_cnt ();

	assign counters_clear = read_hit || cfg_reset ||
		(state_r != cache_pkg::ST_CACHED); // R12
	assign start_cnt.clear = counters_clear;
	assign start_cnt.step = pci_cycle_start; // R6
	assign start_cnt.limit = idle_start_r;
	assign clock_cnt.clear = counters_clear;
	assign clock_cnt.step = 1'b1; // R7 R8
	assign clock_cnt.limit = idle_floor_r;

	idle_counter #(.W(cache_pkg::START_W)) u_start_cnt (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cnt(start_cnt.counter)
	);

	idle_counter #(.W(cache_pkg::CLOCK_W)) u_clock_cnt (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cnt(clock_cnt.counter)
	);

	// ************************************************************
	// discard decision
	// ************************************************************
	logic returned_r;
	logic xfer_end;
	logic any_returned;
	logic miss_limit_hit;
	logic ceiling_hit;
	logic policy_drop;
	logic discard_now;

	assign xfer_end = end_by_master || end_by_retry;
	assign any_returned = returned_r || data_returned;
	// the start-count check is armed only once the clock floor has passed
	assign miss_limit_hit = clock_cnt.reached && start_cnt.reached; // R6 R7
	assign ceiling_hit = (clock_cnt.count >= idle_ceiling_r); // R8

	always_comb begin
		policy_drop = 1'b0;
		case (policy_r)
			cache_pkg::POLICY_LIGHT: begin
				policy_drop = end_by_master && any_returned; // R2
			end
			cache_pkg::POLICY_FULL: begin
				policy_drop = 1'b0; // R3
			end
			default: begin
				policy_drop = data_returned; // R1 R13
			end
		endcase
	end

	// a read hit in the same cycle cancels an idle-limit discard, as the hit restarts idling; a policy drop still discards
	assign discard_now = (state_r == cache_pkg::ST_CACHED) &&
		(policy_drop || (!read_hit && (miss_limit_hit || ceiling_hit)));

	always_ff @(posedge ref_clk) begin
		if (cfg_reset) begin
			returned_r <= 1'b0;
		end else if (xfer_end) begin
			returned_r <= 1'b0;
		end else if (data_returned) begin
			returned_r <= 1'b1;
		end
	end

	// ************************************************************
	// cache state
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cache_pkg::ST_EMPTY: begin
				if (cpl_arrive) begin
					state_nxt = cache_pkg::ST_CACHED;
				end
			end
			cache_pkg::ST_CACHED: begin
				if (discard_now) begin
					state_nxt = cache_pkg::ST_EMPTY;
				end
			end
			default: begin
				state_nxt = cache_pkg::ST_EMPTY;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (cfg_reset) begin
			state_r <= cache_pkg::ST_EMPTY;
			cache_held <= 1'b0;
			cache_discard <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cache_held <= (state_nxt == cache_pkg::ST_CACHED);
			cache_discard <= discard_now;
		end
	end

endmodule

// ==== cache_ctrl_checker.sv ====
// Purpose: port-level assertions for cache_ctrl
// Assumes: one clock domain, reset_n synchronous
// Notes: pin resets are not exercised while events are live
`timescale 1ns/1ps
module cache_ctrl_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// configuration access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic cfg_rd_valid,
	// datapath events and results
	input wire logic cpl_arrive,
	input wire logic read_hit,
	input wire logic data_returned,
	input wire logic end_by_master,
	input wire logic prefetch_enable,
	input wire logic [13:0] prefetch_read_bytes,
	input wire logic [3:0] prefetch_extra_reads,
	input wire logic cache_held,
	input wire logic cache_discard
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire [3:0] bc = cfg_wdata[11:8];
	wire [1:0] pc = cfg_wdata[7:6];
	wire lim_wr = cfg_wr && cfg_addr == 8'hE8 && cfg_be == 2'h3;
	wire [3:0] want_x = (bc > 4'h1) ? bc - 4'h1 : 4'h0;
	wire want_en = bc != 4'h0 && (pc == 2'h1 || pc == 2'h2);

	a_read_answer: assert property (cfg_rd |=> cfg_rd_valid)
		else $error("read not answered");
	a_no_stray_valid: assert property (!cfg_rd |=> !cfg_rd_valid)
		else $error("stray read valid");
	a_limits_rsvd: assert property (cfg_rd && cfg_addr == 8'hE8 |=>
		cfg_rdata[15:12] == 4'h0 && cfg_rdata[5:4] == 2'h0)
		else $error("limits reserved bits set");
	a_start_rsvd: assert property (cfg_rd && cfg_addr == 8'hEA |=>
		cfg_rdata[15:8] == 8'h00) else $error("start limit high bits");
	a_enable_follows: assert property (lim_wr |-> ##2
		prefetch_enable == $past(want_en, 2)) else $error("bad enable");
	a_extra_follows: assert property (lim_wr |-> ##2
		prefetch_extra_reads == $past(want_x, 2)) else $error("bad extra");
	a_bytes_legal: assert property ($onehot(prefetch_read_bytes) &&
		prefetch_read_bytes >= 14'h0040) else $error("bad byte limit");
	a_held_arrive: assert property (cpl_arrive && !cache_held |=>
		cache_held) else $error("arrival not held");
	a_discard_once: assert property (cache_discard |->
		!cache_held ##1 !cache_discard) else $error("discard not a pulse");
	a_hit_blocks: assert property (read_hit && !data_returned &&
		!end_by_master |=> !cache_discard) else $error("discard on hit");
endmodule
bind cache_ctrl cache_ctrl_checker u_cache_ctrl_checker (.ref_clk,
	.reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
	.cfg_rd_valid, .cpl_arrive, .read_hit, .data_returned, .end_by_master,
	.prefetch_enable, .prefetch_read_bytes, .prefetch_extra_reads,
	.cache_held, .cache_discard);

// ==== pci_master_model.sv ====
// Purpose: master-side event source reading through the bridge
// Assumes: every event is a one-cycle pulse on ref_clk
// Notes: gap lets the master come back promptly or slowly
`timescale 1ns/1ps
module pci_master_model (
	// clock
	input wire logic ref_clk,
	// {retry, master end, returned, start, hit, arrive}
	output logic [5:0] ev
);
	initial ev = 6'h00;
	task automatic pulse(input logic [5:0] m, input int gap);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 6'h00;
		repeat (gap) @(posedge ref_clk);
	endtask
endmodule

// ==== tb_cache_ctrl.sv ====
// Purpose: self-checking bench for cache_ctrl
// Assumes: 50 MHz ref_clk, inputs change by nba on the rising edge
// Notes: cfg_be stays 3 except in the byte-lane scenario
`timescale 1ns/1ps
module tb_cache_ctrl;
	localparam logic [5:0] ARR = 6'h01, HIT = 6'h02, STA = 6'h04;
	localparam logic [5:0] RET = 6'h08, MST = 6'h10, RTY = 6'h20;
	logic ref_clk, reset_n, link_side_reset_n, global_pin_reset_n;
	logic cfg_wr, cfg_rd, cfg_rd_valid, prefetch_enable;
	logic cache_held, cache_discard;
	logic [7:0] cfg_addr;
	logic [1:0] cfg_be;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [13:0] prefetch_read_bytes;
	logic [3:0] prefetch_extra_reads;
	logic [5:0] ev;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	cache_ctrl u_cache_ctrl (.ref_clk, .reset_n, .link_side_reset_n,
		.global_pin_reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_rd_valid, .cpl_arrive(ev[0]),
		.read_hit(ev[1]), .pci_cycle_start(ev[2]),
		.data_returned(ev[3]), .end_by_master(ev[4]),
		.end_by_retry(ev[5]), .prefetch_enable, .prefetch_read_bytes,
		.prefetch_extra_reads, .cache_held, .cache_discard);
	pci_master_model u_pci_master_model (.ref_clk, .ev);
	// ****************************************
	// clock, watchdog and reporting
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// bus cycles and helpers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge ref_clk);
		cfg_rd <= 1'b0;
		@(posedge ref_clk);
		chk("rd_valid", 16'(cfg_rd_valid), 16'h0001);
		chk(a == 8'hE8 ? "limits" : "reg", cfg_rdata, e);
	endtask
	// pin must stay low past the 3-stage synchroniser
	task automatic pin_reset(input logic link);
		@(posedge ref_clk);
		if (link) link_side_reset_n <= 1'b0;
		else global_pin_reset_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		link_side_reset_n <= 1'b1;
		global_pin_reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic wait_drop(output int n);
		n = 0;
		while (cache_discard !== 1'b1 && n < 600) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_defaults();
		rd(8'hE8, 16'h0000);
		rd(8'hEA, 16'h0008);
		rd(8'hEC, 16'h007F);
		rd(8'hEE, 16'h01C0);
		rd(8'hE0, 16'h0000);
		chk("bytes", 16'(prefetch_read_bytes), 16'h0040);
	endtask
	task automatic t_reserved();
		logic [7:0] a[4] = '{8'hE8, 8'hEA, 8'hEC, 8'hEE};
		logic [15:0] m[4] = '{16'h0FCF, 16'h00FF, 16'h0FFF, 16'h0FFF};
		for (int i = 0; i < 4; i++) begin
			wr(a[i], 16'hFFFF);
			rd(a[i], m[i]);
		end
		wr(8'hE2, 16'hFFFF);
		rd(8'hE2, 16'h0000);
	endtask
	// single-lane writes must leave the other byte at its old value
	task automatic t_lanes();
		cfg_be <= 2'h1;
		wr(8'hEE, 16'hFABC);
		cfg_be <= 2'h2;
		wr(8'hEC, 16'hFABC);
		wr(8'hE8, 16'hFFFF);
		cfg_be <= 2'h3;
		rd(8'hEE, 16'h01BC);
		rd(8'hEC, 16'h0A7F);
		rd(8'hE8, 16'h0F00);
	endtask
	task automatic t_fields();
		logic [3:0] c, x;
		logic [13:0] b;
		logic e;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			wr(8'hE8, {4'h0, c, c[1:0], 2'h0, c});
			@(posedge ref_clk);
			x = (c > 4'h1) ? c - 4'h1 : 4'h0;
			b = (c > 4'h7) ? 14'h2000 : 14'h0040 << c;
			e = c != 4'h0 && (c[1:0] == 2'h1 || c[1:0] == 2'h2);
			chk("bytes", 16'(prefetch_read_bytes), 16'(b));
			chk("extra", 16'(prefetch_extra_reads), 16'(x));
			chk("enable", 16'(prefetch_enable), 16'(e));
		end
	endtask
	task automatic t_policy();
		for (int p = 0; p < 4; p++) begin
			wr(8'hE8, {4'h0, 4'h1, p[1:0], 6'h00});
			u_pci_master_model.pulse(ARR, 1);
			chk("held", 16'(cache_held), 16'h0001);
			u_pci_master_model.pulse(RET | RTY, 0);
			@(posedge ref_clk);
			chk("drop", 16'(cache_discard), 16'(p == 0 || p == 3));
			u_pci_master_model.pulse(RET | MST, 0);
			@(posedge ref_clk);
			chk("drop", 16'(cache_discard), 16'(p == 1));
			chk("held", 16'(cache_held), 16'(p == 2));
			pin_reset(1'b0);
		end
	endtask
	task automatic t_idle();
		int n;
		wr(8'hE8, 16'h0180);
		wr(8'hEE, 16'h0010);
		wr(8'hEC, 16'h0FFF);
		u_pci_master_model.pulse(ARR, 0);
		wait_drop(n);
		chk("ceiling", 16'(n >= 15 && n <= 20), 16'h0001);
		u_pci_master_model.pulse(ARR, 8);
		u_pci_master_model.pulse(HIT, 0);
		wait_drop(n);
		chk("restart", 16'(n >= 15 && n <= 20), 16'h0001);
		wr(8'hEE, 16'h0FFF);
		wr(8'hEC, 16'h0020);
		wr(8'hEA, 16'h0002);
		u_pci_master_model.pulse(ARR, 0);
		u_pci_master_model.pulse(STA, 0);
		u_pci_master_model.pulse(STA, 0);
		wait_drop(n);
		chk("floor", 16'(n >= 28 && n <= 33), 16'h0001);
		u_pci_master_model.pulse(ARR, 0);
		u_pci_master_model.pulse(STA, 0);
		wait_drop(n);
		chk("starts", 16'(n), 16'h0258);
		u_pci_master_model.pulse(STA, 0);
		wait_drop(n);
		chk("starts", 16'(n <= 3), 16'h0001);
	endtask
	initial begin
		reset_n = 1'b0;
		link_side_reset_n = 1'b1;
		global_pin_reset_n = 1'b1;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 2'h3;
		cfg_wdata = 16'h0000;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_defaults();
		t_reserved();
		pin_reset(1'b1);
		t_defaults();
		t_fields();
		t_policy();
		t_defaults();
		t_lanes();
		t_idle();
		close_out();
	end
endmodule
